// ### cca_pkg.sv
package cca_pkg;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [31:0] ADDR_STATUS = 32'hffff_0500;
   localparam logic [31:0] ADDR_MODE = 32'hffff_0504;
   localparam logic [31:0] ADDR_CTRL = 32'hffff_0508;
   localparam logic [31:0] ADDR_CFG = 32'hffff_0510;
   localparam logic [31:0] ADDR_FILTER = 32'hffff_0518;
   localparam logic [31:0] ADDR_RCL = 32'hffff_0548;
   localparam logic [31:0] ADDR_RCV = 32'hffff_054c;
   localparam logic [31:0] ADDR_LEVEL = 32'hffff_0550;
   localparam logic [31:0] ADDR_TCL = 32'hffff_0554;
   localparam logic [31:0] ADDR_THV = 32'hffff_0558;
   localparam logic [31:0] ADDR_SUM = 32'hffff_055c;
   localparam logic [31:0] ADDR_SUM_LIMIT = 32'hffff_0560;
   localparam logic [31:0] ADDR_TRIM = 32'hffff_057c;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int MODE_OP_LSB = 0;
   localparam int MODE_PWR_LSB = 3;
   localparam int MODE_REF_BIT = 5;
   localparam int MODE_VEN_BIT = 6;
   localparam int MODE_TEN_BIT = 7;
   localparam int CFG_RCNT_BIT = 0;
   localparam int CFG_CMP_LSB = 3;
   localparam int CFG_ACC_LSB = 5;
   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_UNI_BIT = 8;
   localparam int STA_RDY_BIT = 0;
   localparam int STA_CMP_BIT = 3;
   localparam int STA_THR_BIT = 4;
   localparam int STA_ACC_BIT = 5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] FILTER_RST = 16'h0007;
   localparam logic [15:0] RCL_RST = 16'h0001;
   localparam logic [15:0] LEVEL_RST = 16'h0000;
   localparam logic [7:0] TCL_RST = 8'h01;
   localparam logic [31:0] SUM_LIMIT_RST = 32'h0000_0000;
   localparam logic [15:0] TRIM_RST = 16'h8000;

   // ****************************************************************
   // field encodings
   // ****************************************************************
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_LOW = 2'h1;
   localparam logic [1:0] PWR_LOW_PLUS = 2'h2;
   localparam logic [2:0] OP_OFF = 3'h0;
   localparam logic [2:0] OP_CONT = 3'h1;
   localparam logic [2:0] OP_SINGLE = 3'h2;
   localparam logic [2:0] OP_IDLE = 3'h3;
   localparam logic [1:0] CMP_OFF = 2'h0;
   localparam logic [1:0] CMP_FLAG = 2'h1;
   localparam logic [1:0] CMP_COUNT_DEC = 2'h2;
   localparam logic [1:0] CMP_COUNT_RST = 2'h3;
   localparam logic [1:0] ACC_OFF = 2'h0;
   localparam logic [1:0] ACC_SUB = 2'h2;
   localparam logic [3:0] GAIN_LOW = 4'h7;
   localparam logic [3:0] GAIN_LOW_PLUS = 4'h9;

   // ****************************************************************
   // modulator clock enables
   // ****************************************************************
   localparam int NCO_W = 24;
   localparam longint CLK_HZ = 20_000_000;
   localparam longint MOD_NORMAL_HZ = 512_000;
   localparam longint MOD_LOW_HZ = 131_000;
   localparam logic [NCO_W-1:0] NCO_INC_NORMAL = NCO_W'((MOD_NORMAL_HZ << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] NCO_INC_LOW = NCO_W'((MOD_LOW_HZ << NCO_W) / CLK_HZ);

endpackage

// ### cca_nco.sv
`timescale 1ns/10ps
module cca_nco #(
   parameter int W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // rate
   input wire logic run,
   input wire logic [W-1:0] inc,
   // enable pulse
   output logic tick
);

   if (W < 8) begin : g_chk
      $error("cca_nco: W too small");
   end

   logic [W:0] phase;
   wire [W:0] next_phase = {1'b0, phase[W-1:0]} + {1'b0, inc};

   // the carry out is a one-cycle enable; the average rate keeps the fraction
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= '0;
         tick <= 1'b0;
      end else begin
         phase <= run ? next_phase : '0;
         tick <= run & next_phase[W];
      end
   end

endmodule

// ### cca_evt_counter.sv
`timescale 1ns/10ps
module cca_evt_counter #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic clear,
   input wire logic step,
   input wire logic at_or_above,
   input wire logic reset_on_below,
   // count
   output logic [W-1:0] count
);

   if (W < 1) begin : g_chk
      $error("cca_evt_counter: W must be positive");
   end

   wire at_max = &count;
   wire at_zero = ~|count;

   // saturating both ways so a long run of results never wraps the count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (step) begin
         if (at_or_above) begin
            if (!at_max) count <= count + W'(1);
         end else if (reset_on_below) begin
            count <= '0;
         end else if (!at_zero) begin
            count <= count - W'(1);
         end
      end
   end

endmodule

// ### cca_current_ctrl.sv
`timescale 1ns/10ps
module cca_current_ctrl #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // current conversion results
   input wire logic cur_result_valid,
   input wire logic [15:0] cur_result,
   // converter control
   output logic [1:0] power_mode,
   output logic [2:0] op_mode,
   output logic [2:0] chan_enable,
   output logic mod_clk_en,
   output logic [3:0] gain_code,
   output logic use_lp_ref,
   output logic [15:0] lp_ref_trim,
   output logic [15:0] filter_config,
   output logic converter_event
);
   import cca_pkg::*;

   if (CNT_W != 8) begin : g_chk
      $error("cca_current_ctrl: the event counter is 8 bits wide");
   end

   // ****************************************************************
   // bus slave
   // ****************************************************************
   logic wr_pend;
   logic [31:0] wr_addr;
   wire take = hsel & hready & htrans[1];
   wire take_wr = take & hwrite;
   wire take_rd = take & ~hwrite;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0000_0000;
      end else begin
         wr_pend <= take_wr;
         if (take_wr) wr_addr <= haddr;
      end
   end

   // no wait states and never an error
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   wire we_status = wr_pend & (wr_addr == ADDR_STATUS);
   wire we_mode = wr_pend & (wr_addr == ADDR_MODE);
   wire we_ctrl = wr_pend & (wr_addr == ADDR_CTRL);
   wire we_cfg = wr_pend & (wr_addr == ADDR_CFG);
   wire we_filter = wr_pend & (wr_addr == ADDR_FILTER);
   wire we_rcl = wr_pend & (wr_addr == ADDR_RCL);
   wire we_level = wr_pend & (wr_addr == ADDR_LEVEL);
   wire we_tcl = wr_pend & (wr_addr == ADDR_TCL);
   wire we_limit = wr_pend & (wr_addr == ADDR_SUM_LIMIT);
   wire we_trim = wr_pend & (wr_addr == ADDR_TRIM);
   wire reconfig = we_mode | we_ctrl;

   // ****************************************************************
   // software registers
   // ****************************************************************
   logic [7:0] mode_reg;
   logic [7:0] cfg_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] rcl_reg;
   logic [15:0] level_reg;
   logic [7:0] tcl_reg;
   logic [31:0] limit_reg;
   logic [7:0] status_reg;
   logic [31:0] sum_reg;
   logic [15:0] rcv_reg;
   logic [CNT_W-1:0] thv;

   wire [2:0] op_field = mode_reg[MODE_OP_LSB +: 3];
   wire single_done = cur_result_valid & (op_field == OP_SINGLE);

   // the mode register holds the power and op mode fields; a single conversion's result sets op back to off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= MODE_RST;
      end else if (we_mode) begin
         mode_reg <= hwdata[7:0];
      end else if (single_done) begin
         mode_reg[MODE_OP_LSB +: 3] <= OP_OFF;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_reg <= CFG_RST;
         ctrl_reg <= CTRL_RST;
         filter_config <= FILTER_RST;
         rcl_reg <= RCL_RST;
      end else begin
         if (we_cfg) cfg_reg <= hwdata[7:0];
         if (we_ctrl) ctrl_reg <= hwdata[15:0];
         if (we_filter) filter_config <= hwdata[15:0];
         if (we_rcl) rcl_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_reg <= LEVEL_RST;
         tcl_reg <= TCL_RST;
         limit_reg <= SUM_LIMIT_RST;
         lp_ref_trim <= TRIM_RST;
      end else begin
         if (we_level) level_reg <= hwdata[15:0];
         if (we_tcl) tcl_reg <= hwdata[7:0];
         if (we_limit) limit_reg <= hwdata;
         if (we_trim) lp_ref_trim <= hwdata[15:0];
      end
   end

   // ****************************************************************
   // result magnitude and comparator
   // ****************************************************************
   // comparator, counters and sum ignore the power mode on purpose
   wire uni = ctrl_reg[CTRL_UNI_BIT];
   wire [15:0] res_neg = 16'(~cur_result + 16'h0001);
   wire [15:0] res_abs = (uni | ~cur_result[15]) ? cur_result : res_neg;
   wire [15:0] level_eff = uni ? level_reg : {1'b0, level_reg[14:0]};
   wire res_above = res_abs > level_eff;
   wire res_at_or_above = res_abs >= level_eff;
   wire [1:0] cmp_mode = cfg_reg[CFG_CMP_LSB +: 2];
   wire cmp_count = cmp_mode[1];
   wire cmp_flag_set = cur_result_valid & (cmp_mode == CMP_FLAG) & res_above;

   cca_evt_counter #(
      .W(CNT_W)
   ) u_thv (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(reconfig | ~cmp_count),
      .step(cur_result_valid & cmp_count),
      .at_or_above(res_at_or_above),
      .reset_on_below(cmp_mode == CMP_COUNT_RST),
      .count(thv)
   );

   wire thr_set = cmp_count & (thv == tcl_reg);

   // ****************************************************************
   // accumulator
   // ****************************************************************
   // a 32-bit sum wraps silently; software must bound the run length
   wire [1:0] acc_mode = cfg_reg[CFG_ACC_LSB +: 2];
   wire acc_on = acc_mode != ACC_OFF;
   wire [31:0] res_ext = uni ? {16'h0000, cur_result} : {{16{cur_result[15]}}, cur_result};
   wire [31:0] next_sum = (acc_mode == ACC_SUB) ? 32'(sum_reg - res_ext) : 32'(sum_reg + res_ext);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sum_reg <= 32'h0000_0000;
      end else if (!acc_on || reconfig) begin
         sum_reg <= 32'h0000_0000;
      end else if (cur_result_valid) begin
         sum_reg <= next_sum;
      end
   end

   wire [31:0] sum_neg = 32'(~sum_reg + 32'h0000_0001);
   wire [31:0] sum_abs = sum_reg[31] ? sum_neg : sum_reg;
   wire sum_over_uni = sum_reg > {16'h0000, limit_reg[15:0]};
   wire sum_over_twos = sum_abs > {17'h0_0000, limit_reg[14:0]};
   wire acc_set = acc_on & (uni ? sum_over_uni : sum_over_twos);

   // ****************************************************************
   // result counter
   // ****************************************************************
   wire rcnt_on = cfg_reg[CFG_RCNT_BIT];
   wire [15:0] rcv_inc = 16'(rcv_reg + 16'h0001);
   wire rcv_hit = rcv_inc == rcl_reg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rcv_reg <= 16'h0000;
      end else if (reconfig || !rcnt_on) begin
         rcv_reg <= 16'h0000;
      end else if (cur_result_valid) begin
         rcv_reg <= rcv_hit ? 16'h0000 : rcv_inc;
      end
   end

   // with the counter on, ready marks only every limit-th result
   wire rdy_set = cur_result_valid & (~rcnt_on | rcv_hit);

   // ****************************************************************
   // status, write one to clear; a same-cycle set wins
   // ****************************************************************
   logic [7:0] status_set;
   assign status_set = (8'(rdy_set) << STA_RDY_BIT) | (8'(cmp_flag_set) << STA_CMP_BIT)
                     | (8'(thr_set) << STA_THR_BIT) | (8'(acc_set) << STA_ACC_BIT);
   wire [7:0] status_clr = we_status ? hwdata[7:0] : 8'h00;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_reg <= 8'h00;
         converter_event <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~status_clr) | status_set;
         converter_event <= |((status_reg & ~status_clr) | status_set);
      end
   end

   // ****************************************************************
   // power mode decode
   // ****************************************************************
   wire [1:0] pwr_field = mode_reg[MODE_PWR_LSB +: 2];
   wire low_pwr = pwr_field != PWR_NORMAL;
   wire running = (op_field == OP_CONT) | (op_field == OP_SINGLE);
   wire [3:0] gain_sel = (pwr_field == PWR_LOW_PLUS) ? GAIN_LOW_PLUS :
                         low_pwr ? GAIN_LOW : ctrl_reg[CTRL_GAIN_LSB +: 4];
   wire [2:0] chan_sel = {~low_pwr & mode_reg[MODE_TEN_BIT], ~low_pwr & mode_reg[MODE_VEN_BIT], 1'b1};
   wire [NCO_W-1:0] nco_inc = low_pwr ? NCO_INC_LOW : NCO_INC_NORMAL;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_mode <= PWR_NORMAL;
         op_mode <= OP_OFF;
         chan_enable <= 3'h0;
         gain_code <= 4'h0;
         use_lp_ref <= 1'b0;
      end else begin
         power_mode <= pwr_field;
         op_mode <= op_field;
         chan_enable <= running ? chan_sel : 3'h0;
         gain_code <= gain_sel;
         use_lp_ref <= low_pwr & ~mode_reg[MODE_REF_BIT];
      end
   end

   cca_nco #(
      .W(NCO_W)
   ) u_mod_clk (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(running | (op_field == OP_IDLE)),
      .inc(nco_inc),
      .tick(mod_clk_en)
   );

   // ****************************************************************
   // read data
   // ****************************************************************
   // read data is sampled in the address phase, so a read right behind a
   // write to the same register returns the value before that write
   wire [31:0] rd_data =
      (haddr == ADDR_STATUS) ? {24'h00_0000, status_reg} :
      (haddr == ADDR_MODE) ? {24'h00_0000, mode_reg} :
      (haddr == ADDR_CTRL) ? {16'h0000, ctrl_reg} :
      (haddr == ADDR_CFG) ? {24'h00_0000, cfg_reg} :
      (haddr == ADDR_FILTER) ? {16'h0000, filter_config} :
      (haddr == ADDR_RCL) ? {16'h0000, rcl_reg} :
      (haddr == ADDR_RCV) ? {16'h0000, rcv_reg} :
      (haddr == ADDR_LEVEL) ? {16'h0000, level_reg} :
      (haddr == ADDR_TCL) ? {24'h00_0000, tcl_reg} :
      (haddr == ADDR_THV) ? {24'h00_0000, thv} :
      (haddr == ADDR_SUM) ? sum_reg :
      (haddr == ADDR_SUM_LIMIT) ? limit_reg :
      (haddr == ADDR_TRIM) ? {16'h0000, lp_ref_trim} : 32'h0000_0000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (take_rd) begin
         hrdata <= rd_data;
      end
   end

endmodule

// ### cca_result_src.sv
`timescale 1ns/10ps
module cca_result_src (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // request from the bench
   input wire logic fire,
   input wire logic [15:0] value,
   // result towards the block
   output logic cur_result_valid,
   output logic [15:0] cur_result
);
   // ****
   // one-cycle result strobe
   // ****
   // between results the line toggles, so a stale value never passes for a fresh one
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_result_valid <= 1'b0;
         cur_result <= 16'h0000;
      end else begin
         cur_result_valid <= fire;
         cur_result <= fire ? value : ~cur_result;
      end
   end
endmodule

// ### cca_current_ctrl_checker.sv
`timescale 1ns/10ps
module cca_current_ctrl_checker #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // converter
   input wire logic cur_result_valid,
   input wire logic [1:0] power_mode,
   input wire logic [2:0] op_mode,
   input wire logic [2:0] chan_enable,
   input wire logic mod_clk_en,
   input wire logic [3:0] gain_code,
   input wire logic use_lp_ref
);
   import cca_pkg::*;
   // ****
   // helper logic
   // ****
   logic mode_wr;
   logic mode_chk;
   logic [1:0] mode_exp;
   wire addr_mode = hsel && hready && htrans[1] && hwrite && haddr == ADDR_MODE;
   // a mode write may restart the rate generator, so it releases the rate checks
   wire norm_esc = power_mode != PWR_NORMAL || op_mode == OP_OFF || mode_wr;
   wire low_esc = power_mode != PWR_LOW || op_mode == OP_OFF || mode_wr;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_wr <= 1'b0;
         mode_chk <= 1'b0;
         mode_exp <= 2'h0;
      end else begin
         mode_wr <= addr_mode;
         mode_chk <= mode_wr;
         if (mode_wr) begin
            mode_exp <= hwdata[MODE_PWR_LSB+:2];
         end
      end
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence quiet_norm_seq;
      (!mod_clk_en || norm_esc) [*8];
   endsequence
   sequence quiet_low_seq;
      (!mod_clk_en || low_esc) [*8];
   endsequence
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   mode_power_a: assert property (mode_chk |-> ##[0:1] power_mode == mode_exp)
      else $error("power mode does not follow mode write");
   single_off_a: assert property (op_mode == OP_SINGLE && cur_result_valid && !mode_wr |-> ##[1:2] op_mode == OP_OFF)
      else $error("single conversion did not power down");
   low_gain_a: assert property ((power_mode == PWR_LOW) [*2] |-> gain_code == GAIN_LOW && chan_enable[2:1] == 2'h0)
      else $error("low power gain or channels wrong");
   plus_gain_a: assert property ((power_mode == PWR_LOW_PLUS) [*2] |-> gain_code == GAIN_LOW_PLUS)
      else $error("low power plus gain wrong");
   norm_ref_a: assert property ((power_mode == PWR_NORMAL) [*2] |-> !use_lp_ref)
      else $error("low power reference used in normal mode");
   off_quiet_a: assert property ((op_mode == OP_OFF) [*2] |-> !mod_clk_en)
      else $error("modulator clock runs while off");
   norm_rate_a: assert property (mod_clk_en && !norm_esc |=> quiet_norm_seq ##[1:40] (mod_clk_en || norm_esc))
      else $error("normal modulator rate wrong");
   low_rate_a: assert property (mod_clk_en && !low_esc |=> quiet_low_seq ##[1:160] (mod_clk_en || low_esc))
      else $error("low power modulator rate wrong");
endmodule
bind cca_current_ctrl cca_current_ctrl_checker #(.CNT_W(CNT_W)) chk_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .cur_result_valid(cur_result_valid), .power_mode(power_mode), .op_mode(op_mode),
   .chan_enable(chan_enable), .mod_clk_en(mod_clk_en), .gain_code(gain_code), .use_lp_ref(use_lp_ref));

// ### tb.sv
`timescale 1ns/10ps
module tb;
   import cca_pkg::*;
   logic clk, sys_rst, hsel, hwrite, fire, cur_result_valid, hreadyout, hresp, mod_clk_en, use_lp_ref, converter_event;
   logic [1:0] htrans, power_mode;
   logic [2:0] hsize, op_mode, chan_enable;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [15:0] value, cur_result, lp_ref_trim, filter_config;
   logic [3:0] gain_code;
   wire hready = hreadyout;
   int fails = 0;
   int comparisons = 0;
   cca_current_ctrl #(.CNT_W(8)) dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cur_result_valid(cur_result_valid), .cur_result(cur_result), .power_mode(power_mode),
      .op_mode(op_mode), .chan_enable(chan_enable), .mod_clk_en(mod_clk_en), .gain_code(gain_code),
      .use_lp_ref(use_lp_ref), .lp_ref_trim(lp_ref_trim), .filter_config(filter_config),
      .converter_event(converter_event));
   cca_result_src src_u (.clk(clk), .sys_rst(sys_rst), .fire(fire), .value(value),
      .cur_result_valid(cur_result_valid), .cur_result(cur_result));
   always #25 clk = ~clk;
   // ****
   // tasks
   // ****
   task automatic finish_test;
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer, then an idle cycle so a following read sees the update
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rv = hrdata;
      @(posedge clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      // outputs decoded from a register are launched one edge after it; let that edge pass
      @(posedge clk);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000);
      chk(rv, e);
   endtask
   task automatic send(input logic [15:0] v);
      fire <= 1'b1;
      value <= v;
      @(posedge clk);
      fire <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // ****
   // watchdog
   // ****
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      finish_test;
   end
   // ****
   // tests
   // ****
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      {hsel, hwrite, fire} = 3'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      value = 16'h0000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk(lp_ref_trim, TRIM_RST);
      chk(filter_config, FILTER_RST);
      rd(ADDR_TRIM, 32'h0000_8000);
      rd(ADDR_SUM_LIMIT, 32'h0000_0000);
      rd(ADDR_SUM, 32'h0000_0000);
      rd(32'hffff_05f0, 32'h0000_0000);
      wr(ADDR_TRIM, 32'h0000_7eb9);
      rd(ADDR_TRIM, 32'h0000_7eb9);
      chk(lp_ref_trim, 16'h7eb9);
      wr(ADDR_CTRL, 32'h0000_8007);
      wr(ADDR_MODE, 32'h0000_0009);
      chk({power_mode, gain_code, use_lp_ref, chan_enable}, {PWR_LOW, GAIN_LOW, 1'b1, 3'h1});
      repeat (4000) @(posedge clk);
      wr(ADDR_MODE, 32'h0000_00c3);
      repeat (20000) @(posedge clk);
      wr(ADDR_MODE, 32'h0000_00c1);
      chk({op_mode, chan_enable, use_lp_ref, gain_code}, {OP_CONT, 3'h7, 1'b0, 4'h7});
      wr(ADDR_MODE, 32'h0000_00d1);
      chk({gain_code, use_lp_ref, chan_enable}, {GAIN_LOW_PLUS, 1'b1, 3'h1});
      wr(ADDR_MODE, 32'h0000_00f1);
      chk(use_lp_ref, 1'b0);
      wr(ADDR_MODE, 32'h0000_0001);
      wr(ADDR_SUM_LIMIT, 32'hffff_8064);
      wr(ADDR_CFG, 32'h0000_0020);
      send(16'h005a);
      rd(ADDR_STATUS, 32'h0000_0001);
      send(16'hffe2);
      send(16'h0032);
      rd(ADDR_STATUS, 32'h0000_0021);
      chk(converter_event, 1'b1);
      rd(ADDR_SUM, 32'h0000_006e);
      wr(ADDR_CFG, 32'h0000_0040);
      send(16'h000a);
      wr(ADDR_SUM, 32'h0000_1234);
      rd(ADDR_SUM, 32'h0000_0064);
      wr(ADDR_STATUS, 32'h0000_003f);
      chk(converter_event, 1'b0);
      wr(ADDR_CFG, 32'h0000_0000);
      rd(ADDR_SUM, 32'h0000_0000);
      wr(ADDR_CFG, 32'h0000_0020);
      send(16'h0007);
      rd(ADDR_SUM, 32'h0000_0007);
      wr(ADDR_CTRL, 32'h0000_8107);
      rd(ADDR_SUM, 32'h0000_0000);
      wr(ADDR_STATUS, 32'h0000_003f);
      send(16'h8000);
      rd(ADDR_STATUS, 32'h0000_0001);
      send(16'h0100);
      rd(ADDR_STATUS, 32'h0000_0021);
      wr(ADDR_CFG, 32'h0000_0008);
      wr(ADDR_CTRL, 32'h0000_8007);
      wr(ADDR_LEVEL, 32'h0000_0032);
      wr(ADDR_STATUS, 32'h0000_003f);
      send(16'h0032);
      rd(ADDR_STATUS, 32'h0000_0001);
      send(16'hffcd);
      rd(ADDR_STATUS, 32'h0000_0009);
      wr(ADDR_CFG, 32'h0000_0010);
      wr(ADDR_TCL, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_8007);
      wr(ADDR_STATUS, 32'h0000_003f);
      send(16'h003c);
      rd(ADDR_THV, 32'h0000_0001);
      send(16'h000a);
      rd(ADDR_THV, 32'h0000_0000);
      send(16'h0032);
      send(16'hffb0);
      rd(ADDR_THV, 32'h0000_0002);
      rd(ADDR_STATUS, 32'h0000_0011);
      chk(converter_event, 1'b1);
      wr(ADDR_CFG, 32'h0000_0018);
      send(16'h000a);
      rd(ADDR_THV, 32'h0000_0000);
      wr(ADDR_CFG, 32'h0000_0001);
      wr(ADDR_RCL, 32'h0000_0003);
      wr(ADDR_CTRL, 32'h0000_8007);
      wr(ADDR_STATUS, 32'h0000_003f);
      send(16'h0001);
      send(16'h0002);
      rd(ADDR_RCV, 32'h0000_0002);
      rd(ADDR_STATUS, 32'h0000_0000);
      send(16'h0003);
      rd(ADDR_RCV, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0001);
      send(16'h0004);
      wr(ADDR_MODE, 32'h0000_0009);
      rd(ADDR_RCV, 32'h0000_0000);
      wr(ADDR_CFG, 32'h0000_0020);
      send(16'h0009);
      rd(ADDR_SUM, 32'h0000_0009);
      wr(ADDR_MODE, 32'h0000_0002);
      chk(op_mode, OP_SINGLE);
      send(16'h0005);
      // op_mode lags the mode register by one edge
      @(posedge clk);
      chk({op_mode, chan_enable}, {OP_OFF, 3'h0});
      finish_test;
   end
endmodule
